// ### logic/trim_volume_pkg.sv
// constants, field layout and carrier types for the channel trim/volume bank
// assumes an 8-bit register address space behind the serial control port
package trim_volume_pkg;
    // register offsets
    localparam logic [7:0] CH2_GAIN_TRIM_ADDR = 8'h44;
    localparam logic [7:0] CH2_PHASE_TRIM_ADDR = 8'h45;
    localparam logic [7:0] CH3_VOLUME_ADDR = 8'h48;
    localparam logic [7:0] CH3_GAIN_TRIM_ADDR = 8'h49;
    // reset values
    localparam logic [7:0] GAIN_TRIM_RESET = 8'h80;
    localparam logic [7:0] PHASE_TRIM_RESET = 8'h00;
    localparam logic [7:0] VOLUME_RESET = 8'hC9;
    // field positions
    localparam int TRIM_CODE_LSB = 4;
    localparam int TRIM_CODE_MSB = 7;
    localparam logic [3:0] TRIM_RSVD_VALUE = 4'h0;
    // arithmetic: unity gain in q1.15, sample width, volume octave split
    localparam int SAMPLE_W = 24;
    localparam int FRAC_BITS = 15;
    localparam logic [7:0] VOLUME_MUTE_CODE = 8'h00;
    localparam logic [8:0] VOLUME_OFFSET = 9'h00F;
    localparam logic [8:0] STEPS_PER_OCTAVE = 9'h00C;
    localparam logic [8:0] UNITY_OCTAVE = 9'h012;
    localparam int PHASE_DEPTH = 256;

    // one decimated sample with its strobe
    typedef struct packed {
        logic valid;
        logic signed [SAMPLE_W-1:0] data;
    } sample_s;

    // register access request from the control port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
endpackage : trim_volume_pkg

// ### logic/channel_trim_volume_regs.sv
// trim/volume register bank for channels 2 and 3 plus the scaling datapath
// assumes the serial control port decodes frames into single-cycle
// register strobes; samples and modulator ticks are synchronous to clk_i
`timescale 1ns/100ps
module channel_trim_volume_regs
    import trim_volume_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire reg_req_s reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire logic mod_tick_i,
    input wire logic ch2_mod_bit_i,
    output logic ch2_mod_bit_o,
    input wire sample_s ch2_sample_i,
    input wire sample_s ch3_sample_i,
    output sample_s ch2_sample_o,
    output sample_s ch3_sample_o
);

    // gain trim factor 10^((code-8)/200) in q1.15, 17 bits unsigned
    function automatic logic [16:0] trim_factor(input logic [3:0] code);
        logic [16:0] f;
        f = 17'h0_8000;
        unique case (code)
            4'h0: f = 17'h0_74BD;
            4'h1: f = 17'h0_7617;
            4'h2: f = 17'h0_7775;
            4'h3: f = 17'h0_78D7;
            4'h4: f = 17'h0_7A3D;
            4'h5: f = 17'h0_7BA8;
            4'h6: f = 17'h0_7D16;
            4'h7: f = 17'h0_7E89;
            4'h8: f = 17'h0_8000;
            4'h9: f = 17'h0_817C;
            4'hA: f = 17'h0_82FB;
            4'hB: f = 17'h0_8480;
            4'hC: f = 17'h0_8608;
            4'hD: f = 17'h0_8796;
            4'hE: f = 17'h0_8928;
            4'hF: f = 17'h0_8ABE;
        endcase
        return f;
    endfunction : trim_factor

    // volume mantissa 10^(r/40) in q1.15 for r in one 6 dB group
    function automatic logic [15:0] vol_mantissa(input logic [3:0] r);
        logic [15:0] m;
        m = 16'h8000;
        unique case (r)
            4'h1: m = 16'h8796;
            4'h2: m = 16'h8F9E;
            4'h3: m = 16'h9821;
            4'h4: m = 16'hA125;
            4'h5: m = 16'hAAB1;
            4'h6: m = 16'hB4CF;
            4'h7: m = 16'hBF86;
            4'h8: m = 16'hCADF;
            4'h9: m = 16'hD6E4;
            4'hA: m = 16'hE3A0;
            4'hB: m = 16'hF11D;
            default: m = 16'h8000;
        endcase
        return m;
    endfunction : vol_mantissa

    // apply a trim factor to a wide signed value
    function automatic logic signed [63:0] apply_trim(
        input logic signed [63:0] v, input logic [3:0] code);
        logic signed [63:0] p;
        p = v * 64'($signed({1'b0, trim_factor(code)}));
        return p >>> FRAC_BITS;
    endfunction : apply_trim

    // clamp to the sample range; overflow from +27 dB must not wrap
    function automatic logic signed [SAMPLE_W-1:0] saturate(
        input logic signed [63:0] v);
        logic signed [63:0] hi;
        logic signed [63:0] lo;
        hi = 64'sd8388607;
        lo = -64'sd8388608;
        if (v > hi) begin
            return SAMPLE_W'(hi);
        end else if (v < lo) begin
            return SAMPLE_W'(lo);
        end
        return v[SAMPLE_W-1:0];
    endfunction : saturate

    // register file
    logic [7:0] ch2_gain_trim_q, ch2_gain_trim_d;
    logic [7:0] ch2_phase_trim_q, ch2_phase_trim_d;
    logic [7:0] ch3_volume_q, ch3_volume_d;
    logic [7:0] ch3_gain_trim_q, ch3_gain_trim_d;
    logic [7:0] rdata_q, rdata_d;
    logic [3:0] ch2_gain_trim_code;
    logic [3:0] ch3_gain_trim_code;
    logic [7:0] ch2_phase_delay_code;
    logic [7:0] ch3_volume_code;

    assign ch2_gain_trim_code = ch2_gain_trim_q[TRIM_CODE_MSB:TRIM_CODE_LSB];
    assign ch3_gain_trim_code = ch3_gain_trim_q[TRIM_CODE_MSB:TRIM_CODE_LSB];
    assign ch2_phase_delay_code = ch2_phase_trim_q;
    assign ch3_volume_code = ch3_volume_q;

    // writes and registered read data; unmapped addresses read zero
    always_comb begin
        ch2_gain_trim_d = ch2_gain_trim_q;
        ch2_phase_trim_d = ch2_phase_trim_q;
        ch3_volume_d = ch3_volume_q;
        ch3_gain_trim_d = ch3_gain_trim_q;
        rdata_d = rdata_q;
        if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                // reserved nibble is never stored, so it reads zero
                CH2_GAIN_TRIM_ADDR: ch2_gain_trim_d =
                    {reg_req_i.wdata[7:4], TRIM_RSVD_VALUE};
                CH2_PHASE_TRIM_ADDR: ch2_phase_trim_d = reg_req_i.wdata;
                CH3_VOLUME_ADDR: ch3_volume_d = reg_req_i.wdata;
                CH3_GAIN_TRIM_ADDR: ch3_gain_trim_d =
                    {reg_req_i.wdata[7:4], TRIM_RSVD_VALUE};
                default: ;
            endcase
        end
        if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                CH2_GAIN_TRIM_ADDR: rdata_d = ch2_gain_trim_q;
                CH2_PHASE_TRIM_ADDR: rdata_d = ch2_phase_trim_q;
                CH3_VOLUME_ADDR: rdata_d = ch3_volume_q;
                CH3_GAIN_TRIM_ADDR: rdata_d = ch3_gain_trim_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // register state; reset values give unity trim and 0 dB volume
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ch2_gain_trim_q <= GAIN_TRIM_RESET;
            ch2_phase_trim_q <= PHASE_TRIM_RESET;
            ch3_volume_q <= VOLUME_RESET;
            ch3_gain_trim_q <= GAIN_TRIM_RESET;
            rdata_q <= 8'h00;
        end else begin
            ch2_gain_trim_q <= ch2_gain_trim_d;
            ch2_phase_trim_q <= ch2_phase_trim_d;
            ch3_volume_q <= ch3_volume_d;
            ch3_gain_trim_q <= ch3_gain_trim_d;
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata_o = rdata_q;

    // phase delay line: one bit per modulator tick, 256 deep
    logic delay_mem [PHASE_DEPTH];
    logic [7:0] wr_ptr_q, wr_ptr_d;
    logic mod_bit_q, mod_bit_d;
    logic [7:0] rd_ptr;

    // read the bit written code ticks ago; code 0 bypasses the memory
    always_comb begin
        rd_ptr = wr_ptr_q - ch2_phase_delay_code;
        wr_ptr_d = wr_ptr_q;
        mod_bit_d = mod_bit_q;
        if (mod_tick_i) begin
            wr_ptr_d = wr_ptr_q + 8'h01;
            if (ch2_phase_delay_code == 8'h00) begin
                mod_bit_d = ch2_mod_bit_i;
            end else begin
                mod_bit_d = delay_mem[rd_ptr];
            end
        end
    end

    // memory holds no reset so it can map onto plain storage
    always_ff @(posedge clk_i) begin
        if (mod_tick_i) begin
            delay_mem[wr_ptr_q] <= ch2_mod_bit_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr_q <= 8'h00;
            mod_bit_q <= 1'b0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            mod_bit_q <= mod_bit_d;
        end
    end
    assign ch2_mod_bit_o = mod_bit_q;

    // sample scaling, one cycle latency per channel
    sample_s ch2_out_q, ch2_out_d;
    sample_s ch3_out_q, ch3_out_d;
    logic [8:0] vol_index;
    logic [8:0] vol_octave;
    logic [8:0] vol_step;
    logic signed [63:0] ch2_acc;
    logic signed [63:0] ch3_acc;

    // volume is split into 6 dB octaves and a 0.5 dB mantissa; a binary
    // shift stands for 6 dB, so the curve drifts 0.02 dB per octave
    always_comb begin
        vol_index = {1'b0, ch3_volume_code} + VOLUME_OFFSET;
        vol_octave = vol_index / STEPS_PER_OCTAVE;
        vol_step = vol_index % STEPS_PER_OCTAVE;
        ch2_acc = apply_trim(64'(ch2_sample_i.data),
            ch2_gain_trim_code);
        ch3_acc = apply_trim(64'(ch3_sample_i.data),
            ch3_gain_trim_code);
        ch3_acc = (ch3_acc * 64'($signed({1'b0,
            vol_mantissa(vol_step[3:0])}))) >>> FRAC_BITS;
        if (vol_octave >= UNITY_OCTAVE) begin
            ch3_acc = ch3_acc <<< (vol_octave - UNITY_OCTAVE);
        end else begin
            ch3_acc = ch3_acc >>> (UNITY_OCTAVE - vol_octave);
        end
        ch2_out_d.valid = ch2_sample_i.valid;
        ch2_out_d.data = ch2_sample_i.valid ? saturate(ch2_acc)
            : ch2_out_q.data;
        ch3_out_d.valid = ch3_sample_i.valid;
        ch3_out_d.data = ch3_out_q.data;
        if (ch3_sample_i.valid) begin
            if (ch3_volume_code == VOLUME_MUTE_CODE) begin
                ch3_out_d.data = '0;
            end else begin
                ch3_out_d.data = saturate(ch3_acc);
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ch2_out_q <= '0;
            ch3_out_q <= '0;
        end else begin
            ch2_out_q <= ch2_out_d;
            ch3_out_q <= ch3_out_d;
        end
    end
    assign ch2_sample_o = ch2_out_q;
    assign ch3_sample_o = ch3_out_q;

    // checks beside the logic they guard
    sequence trim_read_s;
        reg_req_i.rd && !reg_req_i.wr &&
            (reg_req_i.addr == CH2_GAIN_TRIM_ADDR ||
             reg_req_i.addr == CH3_GAIN_TRIM_ADDR);
    endsequence

    sequence phase_write_then_read_s;
        (reg_req_i.wr && !reg_req_i.rd &&
            reg_req_i.addr == CH2_PHASE_TRIM_ADDR) ##1
        (reg_req_i.rd && !reg_req_i.wr &&
            reg_req_i.addr == CH2_PHASE_TRIM_ADDR);
    endsequence

    a_trim_rsvd_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        trim_read_s |=> reg_rdata_o[3:0] == 4'h0)
        else $error("reserved trim bits read nonzero");

    a_phase_readback: assert property (@(posedge clk_i) disable iff (reset_i)
        phase_write_then_read_s
            |=> reg_rdata_o == $past(reg_req_i.wdata, 2))
        else $error("phase trim readback mismatch");

    a_reset_values: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(reset_i) |-> ch2_gain_trim_q == 8'h80 &&
            ch3_gain_trim_q == 8'h80 && ch3_volume_q == 8'hC9 &&
            ch2_phase_trim_q == 8'h00)
        else $error("register reset value wrong");

    a_phase_bypass: assert property (@(posedge clk_i) disable iff (reset_i)
        mod_tick_i && ch2_phase_delay_code == 8'h00
            |=> ch2_mod_bit_o == $past(ch2_mod_bit_i))
        else $error("zero phase code added delay");

    a_phase_one_tick: assert property (@(posedge clk_i) disable iff (reset_i)
        (mod_tick_i && ch2_phase_delay_code == 8'h01) ##1
        (mod_tick_i && ch2_phase_delay_code == 8'h01)
            |=> ch2_mod_bit_o == $past(ch2_mod_bit_i, 2))
        else $error("phase code 1 not one tick of delay");

    a_mute_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        ch3_sample_i.valid && ch3_volume_code == 8'h00
            |=> ch3_sample_o.valid && ch3_sample_o.data == '0)
        else $error("muted channel 3 sample not zero");

    a_ch2_unity: assert property (@(posedge clk_i) disable iff (reset_i)
        ch2_sample_i.valid && ch2_gain_trim_code == 4'h8
            |=> ch2_sample_o.data == $past(ch2_sample_i.data))
        else $error("channel 2 unity trim changed sample");

    a_ch3_unity: assert property (@(posedge clk_i) disable iff (reset_i)
        ch3_sample_i.valid && ch3_gain_trim_code == 4'h8 &&
            ch3_volume_code == 8'hC9
            |=> ch3_sample_o.data == $past(ch3_sample_i.data))
        else $error("channel 3 unity volume changed sample");

    // each channel on its own, since samples rarely arrive together
    a_valid_follows: assert property (@(posedge clk_i) disable iff (reset_i)
        (ch2_sample_i.valid |=> ch2_sample_o.valid) and
        (ch3_sample_i.valid |=> ch3_sample_o.valid))
        else $error("scaled sample strobe missing");

endmodule : channel_trim_volume_regs

// ### tb/channel_trim_volume_regs_tb.sv
// self-checking bench for the channel 2/3 trim and volume register bank
// assumes fixed one-cycle register and sample latencies; no bus handshake
`timescale 1ns/100ps
module channel_trim_volume_regs_tb;
    import trim_volume_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    reg_req_s reg_req_i = '0;
    logic [7:0] reg_rdata_o;
    logic mod_tick_i = 1'b0;
    logic ch2_mod_bit_i = 1'b0;
    logic ch2_mod_bit_o;
    sample_s ch2_sample_i = '0;
    sample_s ch3_sample_i = '0;
    sample_s ch2_sample_o;
    sample_s ch3_sample_o;
    int error_cnt = 0;
    int checks_done = 0;
    int tick_cnt = 0;

    channel_trim_volume_regs dut (.clk_i(clk_i), .reset_i(reset_i),
        .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
        .mod_tick_i(mod_tick_i), .ch2_mod_bit_i(ch2_mod_bit_i),
        .ch2_mod_bit_o(ch2_mod_bit_o), .ch2_sample_i(ch2_sample_i),
        .ch3_sample_i(ch3_sample_i), .ch2_sample_o(ch2_sample_o),
        .ch3_sample_o(ch3_sample_o));

    // 100 ns period
    always #50 clk_i = ~clk_i;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic do_reset();
        reset_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
    endtask : do_reset

    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        reg_req_i <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk_i);
        reg_req_i <= '0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clk_i);
        reg_req_i <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk_i);
        reg_req_i <= '0;
        #1;
        check($sformatf("reg %0h", addr), {24'h0, reg_rdata_o}, {24'h0, exp});
    endtask : reg_rd

    // write, then read the same place on the very next edge
    task automatic reg_wr_rd(input logic [7:0] addr, input logic [7:0] data,
                             input logic [7:0] exp);
        @(posedge clk_i);
        reg_req_i <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk_i);
        reg_req_i <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk_i);
        reg_req_i <= '0;
        #1;
        check($sformatf("wr rd %0h", addr), {24'h0, reg_rdata_o},
              {24'h0, exp});
    endtask : reg_wr_rd

    // pseudo pattern of period 256 so every delay code sees distinct bits
    function automatic logic pat(input int t);
        return t[0] ^ t[2] ^ t[5] ^ t[7] ^ (t[3] & t[1]);
    endfunction : pat

    // n ticks back to back, then a quiet gap where the output must stand
    task automatic run_ticks(input int n, input int code);
        for (int k = 0; k <= n; k++) begin
            @(posedge clk_i);
            mod_tick_i <= (k < n);
            ch2_mod_bit_i <= pat(tick_cnt + k);
            #1;
            if (k > 0) check("delayed bit", ch2_mod_bit_o,
                             pat(tick_cnt + k - 1 - code));
        end
        tick_cnt += n;
        repeat (3) @(posedge clk_i);
        #1;
        check("bit held", ch2_mod_bit_o, pat(tick_cnt - 1 - code));
    endtask : run_ticks

    // one sample in, scaled sample out a cycle later within tolerance
    task automatic samp(input bit ch3, input int din, input real gain);
        real want;
        real tol;
        sample_s got;
        want = din * gain;
        if (want > 8388607.0) want = 8388607.0;
        if (want < -8388608.0) want = -8388608.0;
        tol = (want < 0 ? -want : want) * 0.02 + 2.0;
        @(posedge clk_i);
        if (ch3) ch3_sample_i <= '{valid: 1'b1, data: din[23:0]};
        else ch2_sample_i <= '{valid: 1'b1, data: din[23:0]};
        @(posedge clk_i);
        ch2_sample_i <= '0;
        ch3_sample_i <= '0;
        #1;
        got = ch3 ? ch3_sample_o : ch2_sample_o;
        check("out valid", got.valid, 1'b1);
        check("out near", !$isunknown(got.data) &&
              ($itor(got.data) - want <= tol) &&
              (want - $itor(got.data) <= tol), 1'b1);
        @(posedge clk_i);
        #1;
        check("valid pulse", ch3 ? ch3_sample_o.valid : ch2_sample_o.valid,
              1'b0);
        check("data held", ch3 ? ch3_sample_o.data : ch2_sample_o.data,
              got.data);
    endtask : samp

    task automatic t_reset_values();
        reg_rd(CH2_GAIN_TRIM_ADDR, 8'h80);
        reg_rd(CH3_GAIN_TRIM_ADDR, 8'h80);
        reg_rd(CH2_PHASE_TRIM_ADDR, 8'h00);
        reg_rd(CH3_VOLUME_ADDR, 8'hC9);
        $display("test reset values done");
    endtask : t_reset_values

    task automatic t_regs_rw();
        // host keeps the reserved nibble at zero on every trim write
        reg_wr(CH2_GAIN_TRIM_ADDR, 8'hF0);
        reg_rd(CH2_GAIN_TRIM_ADDR, 8'hF0);
        reg_wr(CH3_GAIN_TRIM_ADDR, 8'h30);
        reg_rd(CH3_GAIN_TRIM_ADDR, 8'h30);
        reg_wr(CH2_PHASE_TRIM_ADDR, 8'hA5);
        reg_rd(CH2_PHASE_TRIM_ADDR, 8'hA5);
        reg_wr_rd(CH2_PHASE_TRIM_ADDR, 8'h5A, 8'h5A);
        reg_wr(CH3_VOLUME_ADDR, 8'h00);
        reg_rd(CH3_VOLUME_ADDR, 8'h00);
        // unmapped place: the write is dropped and the read gives zero
        reg_wr(8'h46, 8'h55);
        reg_rd(8'h46, 8'h00);
        $display("test register access done");
    endtask : t_regs_rw

    task automatic t_phase();
        int codes[3] = '{1, 3, 255};
        // fill the whole delay line at code zero before any delay is used
        run_ticks(300, 0);
        foreach (codes[i]) begin
            reg_wr(CH2_PHASE_TRIM_ADDR, codes[i][7:0]);
            run_ticks(20, codes[i]);
        end
        reg_wr(CH2_PHASE_TRIM_ADDR, 8'h00);
        run_ticks(10, 0);
        $display("test phase delay done");
    endtask : t_phase

    task automatic t_samples();
        int tc[3] = '{0, 8, 15};
        int vc[4] = '{1, 189, 201, 255};
        foreach (tc[i]) begin
            reg_wr(CH2_GAIN_TRIM_ADDR, {tc[i][3:0], 4'h0});
            samp(1'b0, 100000, $pow(10.0, (tc[i] - 8) * 0.005));
        end
        samp(1'b1, 1000, 1.0);
        foreach (vc[i]) begin
            reg_wr(CH3_VOLUME_ADDR, vc[i][7:0]);
            samp(1'b1, 100000, $pow(10.0, (vc[i] - 201) * 0.025));
        end
        // full scale at +27 dB must clip, both signs
        samp(1'b1, 8000000, 100.0);
        samp(1'b1, -8000000, 100.0);
        reg_wr(CH3_VOLUME_ADDR, 8'h00);
        samp(1'b1, 4000000, 0.0);
        reg_wr(CH3_VOLUME_ADDR, 8'hC9);
        reg_wr(CH3_GAIN_TRIM_ADDR, 8'h00);
        samp(1'b1, 100000, $pow(10.0, -0.04));
        $display("test sample scaling done");
    endtask : t_samples

    // watchdog: the run is far shorter, so reaching this is a hang
    initial begin
        #5ms;
        error_cnt++;
        end_sim();
    end

    initial begin
        do_reset();
        t_reset_values();
        t_regs_rw();
        do_reset();
        t_reset_values();
        t_phase();
        t_samples();
        end_sim();
    end
endmodule : channel_trim_volume_regs_tb
